// ==== rtl/qsas_pkg.sv ====
package qsas_pkg;
  localparam int SLOT_CYCLES = 16;
  localparam int TRACK_CYCLES = 3;
  localparam logic [4:0] CNT_SLOT = 5'h10;
  localparam logic [4:0] CNT_TRACK_END = 5'h03;
  localparam logic [4:0] CNT_DOUT_FIRST = 5'h04;
  localparam logic [4:0] CNT_CTRL_LAST = 5'h08;
  localparam int CTRL_W = 8;
  localparam int SEL_LO = 3;
  localparam int SEL_MID = 4;
  localparam int SEL_TOP = 5;
  localparam logic [1:0] CHAN_RESET = 2'h0;
  localparam int RES_W = 8;
  localparam logic [7:0] RES_MSB_ONE = 8'h80;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [3:0] BUF_DEPTH = 4'h2;
  typedef enum logic [2:0] {
    QSAS_IDLE = 3'b001,
    QSAS_TRACK = 3'b010,
    QSAS_HOLD = 3'b100
  } qsas_state_type;
endpackage

// ==== rtl/qsas_stream_if.sv ====
`timescale 1ns/1ns
interface qsas_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== rtl/qsas_skid_buf.sv ====
`timescale 1ns/1ns
module qsas_skid_buf
(
  input wire logic clk_in,
  input wire logic rst_in,
  qsas_stream_if.snk up,
  qsas_stream_if.src dn
);
  logic [7:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = up.valid && up.ready;
  wire pop = dn.valid && dn.ready;
  assign up.ready = (cnt_r != 2'h2);
  assign dn.valid = (cnt_r != 2'h0);
  assign dn.data = mem_r[rp_r];
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else
    begin
      if (push)
        mem_r[wp_r] <= up.data;
      wp_r <= wp_r ^ push;
      rp_r <= rp_r ^ pop;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // qsas_skid_buf

// ==== rtl/qsas_sequencer.sv ====
`timescale 1ns/1ns
//Function
// - Track selected input first three clocks
// - Hold and convert clocks four to sixteen
// - Step DAC code through eight trial bits, MSB first
// - Address in, result out each slot
// - Bits 5..3 select next conversion channel
// - Other control bits are ignored
// - Top select bit ignored, low two pick
// - Powered in slot clocks one to fifteen while select low, else down
// - Power down between back-to-back conversions
// - Back-to-back sixteen-clock conversions while low
// - Result shifts out MSB first, clock five
// - Control sampled on first eight rises
// - Data out high-Z while select high
// - First conversion after power-up: input zero
module qsas_sequencer
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic din_in,
  input wire logic comp_above_in,
  output logic dout_out,
  output logic dout_oe_out,
  output logic [1:0] mux_sel_out,
  output logic track_out,
  output logic powered_out,
  output logic [7:0] dac_code_out,
  output logic [7:0] result_out,
  output logic result_valid_out,
  input wire logic result_ready_in
);
  logic [2:0] cs_sync_r;
  logic [2:0] sclk_sync_r;
  logic din_m_r;
  logic din_s_r;
  qsas_pkg::qsas_state_type state_r;
  qsas_pkg::qsas_state_type state_nxt;
  logic [4:0] cnt_r;
  logic [7:0] ctrl_r;
  logic [1:0] chan_r;
  logic [1:0] chan_pend_r;
  logic [7:0] sar_r;
  logic [7:0] bit_r;
  logic dout_bit_r;
  logic [7:0] done_r;
  logic done_vld_r;
  qsas_stream_if buf_in ();
  qsas_stream_if buf_out ();
  // Levels read the second stage; edges read the second and third
  wire cs_low = ~cs_sync_r[1];
  wire cs_fall = cs_sync_r[2] & ~cs_sync_r[1];
  wire sclk_rise = ~sclk_sync_r[2] & sclk_sync_r[1];
  wire sclk_fall_raw = sclk_sync_r[2] & ~sclk_sync_r[1];
  // Falling CS with clock low counts as first falling edge
  wire sclk_fall = (sclk_fall_raw & cs_low) | (cs_fall & ~sclk_sync_r[1]);
  wire slot_end = sclk_fall & (cnt_r == qsas_pkg::CNT_SLOT);
  wire start_slot = sclk_fall & ((state_r == qsas_pkg::QSAS_IDLE) | slot_end);
  wire enter_hold = sclk_fall & (state_r == qsas_pkg::QSAS_TRACK)
    & (cnt_r == qsas_pkg::CNT_TRACK_END);
  wire ctrl_take = sclk_rise & cs_low & (cnt_r <= qsas_pkg::CNT_CTRL_LAST)
    & (cnt_r != qsas_pkg::CNT_ZERO);
  wire ctrl_last = ctrl_take & (cnt_r == qsas_pkg::CNT_CTRL_LAST);
  wire sar_step = sclk_fall & (state_r == qsas_pkg::QSAS_HOLD) & (bit_r != 8'h00);
  wire [7:0] sar_keep = comp_above_in ? (sar_r & ~bit_r) : sar_r;
  wire [7:0] ctrl_word = {ctrl_r[6:0], din_s_r};
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      qsas_pkg::QSAS_IDLE:
        if (start_slot)
          state_nxt = qsas_pkg::QSAS_TRACK;
      qsas_pkg::QSAS_TRACK:
        if (enter_hold)
          state_nxt = qsas_pkg::QSAS_HOLD;
      qsas_pkg::QSAS_HOLD:
        if (start_slot)
          state_nxt = qsas_pkg::QSAS_TRACK;
    endcase
    if (~cs_low)
      state_nxt = qsas_pkg::QSAS_IDLE;
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cs_sync_r <= 3'h7;
      sclk_sync_r <= 3'h7;
      din_m_r <= 1'b0;
      din_s_r <= 1'b0;
    end
    else
    begin
      cs_sync_r <= {cs_sync_r[1:0], cs_n_in};
      sclk_sync_r <= {sclk_sync_r[1:0], sclk_in};
      din_m_r <= din_in;
      din_s_r <= din_m_r;
    end
  end
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_r <= qsas_pkg::QSAS_IDLE;
      cnt_r <= qsas_pkg::CNT_ZERO;
    end
    else
    begin
      state_r <= state_nxt;
      if (~cs_low)
        cnt_r <= qsas_pkg::CNT_ZERO;
      else if (start_slot)
        cnt_r <= 5'h01;
      else if (sclk_fall)
        cnt_r <= cnt_r + 5'h01;
    end
  end
  // Control word and channel selection
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_r <= 8'h00;
      chan_r <= qsas_pkg::CHAN_RESET;
      chan_pend_r <= qsas_pkg::CHAN_RESET;
    end
    else
    begin
      if (ctrl_take)
        ctrl_r <= ctrl_word;
      if (ctrl_last)
        chan_pend_r <= ctrl_word[qsas_pkg::SEL_MID:qsas_pkg::SEL_LO];
      if (start_slot)
        chan_r <= chan_pend_r;
    end
  end
  // SAR conversion; comparator is sampled before each trial bit moves on
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      sar_r <= qsas_pkg::RESULT_RESET;
      bit_r <= 8'h00;
      dout_bit_r <= 1'b0;
      done_r <= qsas_pkg::RESULT_RESET;
      done_vld_r <= 1'b0;
    end
    else
    begin
      done_vld_r <= done_vld_r & ~buf_in.ready;
      if (enter_hold)
      begin
        sar_r <= qsas_pkg::RES_MSB_ONE;
        bit_r <= qsas_pkg::RES_MSB_ONE;
      end
      else if (sar_step)
      begin
        sar_r <= sar_keep | (bit_r >> 1);
        bit_r <= bit_r >> 1;
        if (bit_r == 8'h01)
        begin
          done_r <= sar_keep;
          done_vld_r <= 1'b1;
        end
      end
      // Each bit leaves as it resolves, so no wait for the full word
      if (sar_step)
        dout_bit_r <= |(sar_keep & bit_r);
      else if (sclk_fall)
        dout_bit_r <= 1'b0;
    end
  end
  assign buf_in.valid = done_vld_r;
  assign buf_in.data = done_r;
  assign buf_out.ready = result_ready_in | ~result_valid_out;
  qsas_skid_buf u_buf
  (
    .clk_in(sys_clk_in),
    .rst_in(rst_in),
    .up(buf_in),
    .dn(buf_out)
  );
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      dout_out <= 1'b0;
      dout_oe_out <= 1'b0;
      mux_sel_out <= qsas_pkg::CHAN_RESET;
      track_out <= 1'b0;
      powered_out <= 1'b0;
      dac_code_out <= qsas_pkg::RESULT_RESET;
      result_out <= qsas_pkg::RESULT_RESET;
      result_valid_out <= 1'b0;
    end
    else
    begin
      dout_out <= (state_r == qsas_pkg::QSAS_HOLD) & (cnt_r > qsas_pkg::CNT_DOUT_FIRST)
        & dout_bit_r;
      dout_oe_out <= cs_low;
      mux_sel_out <= chan_r;
      track_out <= cs_low & (state_r == qsas_pkg::QSAS_TRACK);
      // Down when CS high, and after the sixteenth fall until the next
      powered_out <= cs_low & (state_r != qsas_pkg::QSAS_IDLE)
        & (cnt_r != qsas_pkg::CNT_SLOT);
      dac_code_out <= sar_r;
      if (buf_out.valid & buf_out.ready)
      begin
        result_out <= buf_out.data;
        result_valid_out <= 1'b1;
      end
      else if (result_ready_in)
        result_valid_out <= 1'b0;
    end
  end
endmodule // qsas_sequencer

// ==== tb/qsas_properties.sv ====
`timescale 1ns/1ns
module qsas_properties
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic result_ready_in,
  input wire logic dout_oe_out,
  input wire logic [1:0] mux_sel_out,
  input wire logic track_out,
  input wire logic powered_out,
  input wire logic [7:0] result_out,
  input wire logic result_valid_out
);
  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (rst_in);
  // Five samples cover the two-flop sync plus the output register
  chk_oe_cs_high: assert property (cs_n_in [*5] |-> !dout_oe_out)
    else $error("dout driven with select high");
  chk_oe_cs_low: assert property (!cs_n_in [*5] |-> dout_oe_out)
    else $error("dout released with select low");
  chk_power_cs_high: assert property (cs_n_in [*5] |-> !powered_out)
    else $error("powered with select high");
  chk_track_powered: assert property (track_out |-> powered_out && dout_oe_out)
    else $error("track while unpowered");
  chk_track_span: assert property ($rose(track_out) |-> ##[35:40] $fell(track_out))
    else $error("track phase not three serial clocks");
  chk_mux_in_track: assert property ($rose(track_out) |=> $stable(mux_sel_out) [*8])
    else $error("channel moved during track");
  chk_valid_hold: assert property (result_valid_out && !result_ready_in |=>
    result_valid_out && $stable(result_out))
    else $error("result lost while stalled");
  chk_slot_off: assert property ($fell(powered_out) |-> !track_out [*8])
    else $error("track during slot power-down");
  chk_gap_before_track: assert property ($rose(track_out) |-> !$past(powered_out))
    else $error("no power-down before track");
endmodule // qsas_properties
bind qsas_sequencer qsas_properties u_qsas_properties (.*);

// ==== tb/qsas_host.sv ====
`timescale 1ns/1ns
module qsas_host
(
  output logic cs_n_out,
  output logic sclk_out,
  output logic din_out,
  input wire logic dout_in
);
  // Serial clock stands high between frames
  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    din_out = 1'b0;
  end
  // Off the sampling edge, and clock still high when select falls
  task automatic start();
    #11;
    cs_n_out = 1'b0;
    #125;
  endtask
  // Clock parked low, so the select fall is the first falling edge
  task automatic start_low();
    #1;
    sclk_out = 1'b0;
    #125;
    cs_n_out = 1'b0;
  endtask
  task automatic stop();
    cs_n_out = 1'b1;
    din_out = ~din_out;
  endtask
  // One 16-clock slot, so frames stay whole multiples
  task automatic slot(input logic [7:0] ctrl, output logic [7:0] got);
    for (int k = 1; k <= 16; k++)
    begin
      sclk_out = 1'b0;
      din_out = (k <= 8) ? ctrl[8-k] : ~din_out;
      #62;
      sclk_out = 1'b1;
      if (k >= 5 && k <= 12)
        got[12-k] = dout_in;
      #63;
    end
  endtask
endmodule // qsas_host

// ==== tb/quad_channel_serial_adc_sequencer_test.sv ====
`timescale 1ns/1ns
module quad_channel_serial_adc_sequencer_test;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic comp_above_in = 1'b0;
  logic result_ready_in = 1'b0;
  logic cs_n, sclk, din, dout, oe, track, pwr, rv;
  logic [1:0] mux, prev;
  logic [7:0] dac, res, got;
  logic [7:0] lvl [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hf1};
  // Rows: control word, channel it picks for the next slot
  logic [7:0] ctl [6] = '{8'h08, 8'hd0, 8'h3f, 8'h20, 8'hc7, 8'h18};
  logic [1:0] ch [6] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h3};
  logic [7:0] exq [$];
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  qsas_sequencer u_qsas_sequencer (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sclk_in(sclk), .din_in(din), .comp_above_in(comp_above_in), .dout_out(dout),
    .dout_oe_out(oe), .mux_sel_out(mux), .track_out(track), .powered_out(pwr),
    .dac_code_out(dac), .result_out(res), .result_valid_out(rv),
    .result_ready_in(result_ready_in));
  qsas_host u_qsas_host (.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din),
    .dout_in(oe ? dout : ~dout));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e)
    begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      fail_count++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    comp_above_in <= dac > lvl[mux];
    // Stall often so result_out must hold words
    result_ready_in <= cyc[6];
    if (rv && result_ready_in && !rst_in)
      chk(res, exq.pop_front());
    if (cyc == 6000)
    begin
      fail_count++;
      results();
    end
  end
  initial
  begin
    prev = 2'h0;
    repeat (8) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    u_qsas_host.start();
    for (int i = 0; i < 6; i++)
    begin
      exq.push_back(lvl[prev]);
      u_qsas_host.slot(ctl[i], got);
      chk(got, lvl[prev]);
      chk({6'h0, mux}, {6'h0, prev});
      chk({6'h0, pwr, oe}, 8'h01);
      prev = ch[i];
      $display("row %0d done", i);
    end
    u_qsas_host.stop();
    repeat (10) @(posedge sys_clk_in);
    chk({5'h0, oe, pwr, track}, 8'h00);
    exq.push_back(lvl[prev]);
    u_qsas_host.start();
    u_qsas_host.slot(8'h00, got);
    chk(got, lvl[prev]);
    u_qsas_host.stop();
    $display("restart done");
    repeat (10) @(posedge sys_clk_in);
    prev = 2'h0;
    exq.push_back(lvl[prev]);
    u_qsas_host.start_low();
    u_qsas_host.slot(8'h08, got);
    chk(got, lvl[prev]);
    chk({6'h0, mux}, {6'h0, prev});
    u_qsas_host.stop();
    repeat (300) @(posedge sys_clk_in);
    chk(8'(exq.size()), 8'h00);
    $display("clock low start done");
    results();
  end
endmodule // quad_channel_serial_adc_sequencer_test
